// File: logic/mwcb_regs.vh
`ifndef MWCB_REGS_VH
`define MWCB_REGS_VH
// Register indices; the byte address is four times the index
`define MWCB_IX_FEN 10'h01f
`define MWCB_IX_FLT 10'h020
`define MWCB_IX_CEN 10'h021
`define MWCB_IX_POL 10'h0f0
`define MWCB_IX_CAP 10'h1e6
`define MWCB_IX_ST 10'h1f8
`define MWCB_IX_MSK 10'h1f9
`define MWCB_IX_OCC 10'h1fa
// Field positions
`define MWCB_B_EN 0
`define MWCB_B_FLUSH 0
`define MWCB_B_FENCE 1
`define MWCB_B_FIFO 0
`define MWCB_S_DONE 0
`define MWCB_S_ERR 1
`define MWCB_S_AUTO 2
// Fixed byte values
`define MWCB_POL_VAL 8'h00
`define MWCB_CAPB_VAL 8'h01
`define MWCB_ST_RST 3'h0
`define MWCB_MSK_RST 3'h0
// Cache capacity in blocks, fence depth, commit rate divider
`define MWCB_CACHE_BLKS 8'h40
`define MWCB_FENCE_DEP 3'h4
`define MWCB_DIV_LAST 4'h3
`endif

// File: logic/mwcb_top.v
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`include "mwcb_regs.vh"

////////////////////////////////////////////////////////////////////////
// How it works
// - Cache starts off after power-up, reset pin or CMD0.
// - Host writes cache control byte 33; caching follows it.
// - Turning cache off flushes all cached data.
// - Data before a barrier commits before data after it.
// - Within one barrier epoch, commit order is free.
// - Barrier or commit errors show in the status register.
// - Any number of barriers accepted between two flushes.
// - Barrier beyond internal depth triggers an ordinary full flush.
// - Capability byte 486 reads one when barriers supported.
// - Barrier bit written set while supported and enabled, with cache on, performs a barrier.
// - Full or unavailable cache still stores the write directly.
// - In-order flag of policy byte 240 tells in-order commit.
// - In-order device accepts barriers silently, no behaviour change.
// - Policy byte is read-only and never changes.
module mwcb_top (
  input wire ref_clk, // 100 MHz clock
  input wire rst_b, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  input wire hw_rst_pin_b, // Reset pin, async, low
  input wire cmd0_rst, // CMD0 reset pulse
  input wire wr_req, // Write block request pulse
  input wire wr_forced, // Forced or reliable write
  input wire nvm_err, // Programming error pulse
  output reg wr_cached, // Block taken into cache
  output reg wr_direct, // Block sent straight to storage
  output reg nvm_commit, // One cached block committed
  output reg [1:0] nvm_epoch, // Epoch of committed block
  output reg busy, // Busy on data line
  output reg irq // Interrupt level
);

////////////////////////////////////////////////////////////////////////
// Declarations

// Fixed read-only bytes, bit-addressable
localparam [7:0] pol_v = `MWCB_POL_VAL;
localparam [7:0] cap_v = `MWCB_CAPB_VAL;

// Reset pin synchroniser
reg pin_s1_q;
reg pin_s2_q;

// Control bytes, status and mask
reg fen_q;
reg cen_q;
reg flush_q;
reg [2:0] st_q;
reg [2:0] st_d;
reg [2:0] msk_q;

// Epoch ring and occupancy
reg [7:0] cnt_q [0:3];
reg [1:0] hd_q;
reg [1:0] tl_q;
reg [2:0] nep_q;
reg [2:0] nep_d;
reg [8:0] tot_q;
reg [8:0] tot_d;

// Commit pacing and read path
reg [3:0] div_q;
reg [31:0] rd_d;
reg hit_d;

// Bus decode nets
wire [9:0] idx;
wire acc;
wire wr_acc;
wire rd_acc;
wire clr;
wire tick;
wire cen_wr;
wire flt_wr;

// Cache event nets
wire cen_off;
wire fence;
wire fence_adv;
wire fence_over;
wire full;
wire cache_it;
wire direct_it;
wire com;
wire hd_adv;
wire flush_set;
wire flush_done;
integer i;

////////////////////////////////////////////////////////////////////////
// Helpers

// Register index from a word-aligned byte address
function [9:0] word_idx;
  input [11:0] a;
  begin
    word_idx = a[11:2];
  end
endfunction

// Count step for one epoch slot
function [7:0] step;
  input [7:0] c;
  input up;
  input dn;
  begin
    if (up && !dn) begin
      step = c + 8'h01;
    end else if (dn && !up) begin
      step = c - 8'h01;
    end else begin
      step = c;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Reset pin synchroniser
always @(posedge ref_clk or negedge rst_b) begin
  if (!rst_b) begin
    pin_s1_q <= 1'b1; // Idle level, no false clear
    pin_s2_q <= 1'b1;
  end else begin
    pin_s1_q <= hw_rst_pin_b;
    pin_s2_q <= pin_s1_q;
  end
end

// Soft clear from reset pin or CMD0
assign clr = cmd0_rst | ~pin_s2_q;

////////////////////////////////////////////////////////////////////////
// Bus decode
assign idx = word_idx(paddr);
assign acc = psel & penable & pready;
assign wr_acc = acc & pwrite & ~pslverr;
assign rd_acc = acc & ~pwrite & ~pslverr;
// Write strobes for the control bytes
assign cen_wr = wr_acc && (idx == `MWCB_IX_CEN);
assign flt_wr = wr_acc && (idx == `MWCB_IX_FLT);

// Read mux and address map
always @* begin
  rd_d = 32'h0000_0000;
  hit_d = 1'b1;
  if (idx == `MWCB_IX_FEN) begin
    rd_d[`MWCB_B_EN] = fen_q;
  end else if (idx == `MWCB_IX_FLT) begin
    rd_d = 32'h0000_0000;
  end else if (idx == `MWCB_IX_CEN) begin
    rd_d[`MWCB_B_EN] = cen_q;
  end else if (idx == `MWCB_IX_POL) begin
    rd_d[7:0] = `MWCB_POL_VAL;
  end else if (idx == `MWCB_IX_CAP) begin
    rd_d[7:0] = `MWCB_CAPB_VAL;
  end else if (idx == `MWCB_IX_ST) begin
    rd_d[2:0] = st_q;
  end else if (idx == `MWCB_IX_MSK) begin
    rd_d[2:0] = msk_q;
  end else if (idx == `MWCB_IX_OCC) begin
    rd_d[8:0] = tot_q;
    rd_d[18:16] = nep_q;
    rd_d[24] = flush_q;
  end else begin
    hit_d = 1'b0;
  end
end

// Answer in the first access cycle
always @(posedge ref_clk or negedge rst_b) begin
  if (!rst_b) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h0000_0000;
  end else begin
    pready <= psel & ~penable;
    if (psel && !penable) begin
      pslverr <= ~hit_d;
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
    end else begin
      pslverr <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Commit rate divider
always @(posedge ref_clk or negedge rst_b) begin
  if (!rst_b) begin
    div_q <= 4'h0;
  end else if (div_q == `MWCB_DIV_LAST) begin
    div_q <= 4'h0;
  end else begin
    div_q <= div_q + 4'h1;
  end
end

assign tick = (div_q == `MWCB_DIV_LAST);

////////////////////////////////////////////////////////////////////////
// Cache events
assign cen_off = cen_wr & cen_q & ~pwdata[`MWCB_B_EN];
// Barrier only with support, enable, cache on and no in-order policy
assign fence = flt_wr & pwdata[`MWCB_B_FENCE] & fen_q & cen_q
  & cap_v[0] & ~pol_v[`MWCB_B_FIFO];
// Empty current epoch needs no new boundary
assign fence_adv = fence && (cnt_q[tl_q] != 8'h00)
  && (nep_q != `MWCB_FENCE_DEP) && !flush_q;
assign fence_over = fence && (cnt_q[tl_q] != 8'h00)
  && (nep_q == `MWCB_FENCE_DEP);
// Cache holds at most the fixed block count
assign full = (tot_q == {1'b0, `MWCB_CACHE_BLKS});
// Bypass when off, full, forced or flushing
assign cache_it = wr_req & cen_q & ~wr_forced & ~full
  & ~flush_q & ~clr;
assign direct_it = wr_req & ~cache_it & ~clr;
// Commit from the oldest epoch only
assign com = tick && (cnt_q[hd_q] != 8'h00) && !clr;
// Head moves on as its epoch drains, or when found empty behind a barrier
assign hd_adv = (nep_q != 3'h1) && ((cnt_q[hd_q] == 8'h00)
  || (com && (cnt_q[hd_q] == 8'h01)));
assign flush_set = cen_off | fence_over
  | (flt_wr & pwdata[`MWCB_B_FLUSH] & (tot_q != 9'h000));
assign flush_done = flush_q && (tot_q == 9'h000);

// Next occupancy and epoch count
always @* begin
  tot_d = tot_q;
  if (cache_it && !com) begin
    tot_d = tot_q + 9'h001;
  end else if (com && !cache_it) begin
    tot_d = tot_q - 9'h001;
  end
  nep_d = nep_q;
  if (fence_adv && !hd_adv) begin
    nep_d = nep_q + 3'h1;
  end else if (hd_adv && !fence_adv) begin
    nep_d = nep_q - 3'h1;
  end
end

////////////////////////////////////////////////////////////////////////
// Control registers and epoch bookkeeping
always @(posedge ref_clk or negedge rst_b) begin
  if (!rst_b) begin
    fen_q <= 1'b0;
    cen_q <= 1'b0;
    flush_q <= 1'b0;
    hd_q <= 2'h0;
    tl_q <= 2'h0;
    nep_q <= 3'h1;
    tot_q <= 9'h000;
    for (i = 0; i < 4; i = i + 1) begin
      cnt_q[i] <= 8'h00;
    end
  end else if (clr) begin
    fen_q <= 1'b0;
    cen_q <= 1'b0;
    flush_q <= 1'b0;
    hd_q <= 2'h0;
    tl_q <= 2'h0;
    nep_q <= 3'h1;
    tot_q <= 9'h000;
    for (i = 0; i < 4; i = i + 1) begin
      cnt_q[i] <= 8'h00;
    end
  end else begin
    // Host writes to the control bytes
    if (wr_acc && idx == `MWCB_IX_FEN) begin
      fen_q <= pwdata[`MWCB_B_EN];
    end
    if (cen_wr) begin
      cen_q <= pwdata[`MWCB_B_EN];
    end
    if (flush_set) begin
      flush_q <= 1'b1;
    end else if (flush_done) begin
      flush_q <= 1'b0;
    end
    // Per-epoch block counts
    for (i = 0; i < 4; i = i + 1) begin
      cnt_q[i] <= step(cnt_q[i], cache_it && tl_q == i,
        com && hd_q == i);
    end
    // Ring pointers over the epoch slots
    if (fence_adv) begin
      tl_q <= tl_q + 2'h1;
    end
    if (hd_adv) begin
      hd_q <= hd_q + 2'h1;
    end
    nep_q <= nep_d;
    tot_q <= tot_d;
  end
end

////////////////////////////////////////////////////////////////////////
// Status, mask and interrupt
always @* begin
  st_d = st_q;
  // Clear only the bits that the read returned
  if (rd_acc && idx == `MWCB_IX_ST) begin
    st_d = st_q & ~prdata[2:0];
  end
  // Set wins over the read clear
  if (flush_done) begin
    st_d[`MWCB_S_DONE] = 1'b1;
  end
  if (nvm_err) begin
    st_d[`MWCB_S_ERR] = 1'b1;
  end
  if (fence_over) begin
    st_d[`MWCB_S_AUTO] = 1'b1;
  end
end

always @(posedge ref_clk or negedge rst_b) begin
  if (!rst_b) begin
    st_q <= `MWCB_ST_RST;
    msk_q <= `MWCB_MSK_RST;
    irq <= 1'b0;
  end else begin
    st_q <= st_d;
    // Mask write reaches the interrupt at once
    if (wr_acc && idx == `MWCB_IX_MSK) begin
      msk_q <= pwdata[2:0];
      irq <= |(st_d & pwdata[2:0]);
    end else begin
      irq <= |(st_d & msk_q);
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Outputs to the storage side
always @(posedge ref_clk or negedge rst_b) begin
  if (!rst_b) begin
    wr_cached <= 1'b0;
    wr_direct <= 1'b0;
    nvm_commit <= 1'b0;
    nvm_epoch <= 2'h0;
    busy <= 1'b0;
  end else begin
    wr_cached <= cache_it;
    wr_direct <= direct_it;
    nvm_commit <= com;
    if (com) begin
      nvm_epoch <= hd_q;
    end
    // Busy from flush start until cache is empty
    // Soft clear drops it at once
    busy <= ~clr & ((flush_q & ~flush_done) | flush_set);
  end
end

endmodule // mwcb_top

// File: tb/mwcb_checker.sv
`timescale 1ns/10ps
module mwcb_checker (
  input wire ref_clk, // Clock
  input wire rst_b, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pready, // Ready
  input wire pslverr, // Bus error
  input wire cmd0_rst, // Soft reset
  input wire wr_req, // Write
  input wire wr_forced, // Forced
  input wire wr_cached, // Cached
  input wire wr_direct, // Direct
  input wire nvm_commit, // Commit
  input wire busy // Flushing
);
  // One clock, one reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Bus setup cycle; a write outside soft reset
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr;
    wr_req && !cmd0_rst;
  endsequence
  AST_RDY: assert property (s_setup |=> pready)
    else $error("no ready");
  AST_ONE: assert property (pready |=> !pready)
    else $error("long ready");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("lone error");
  AST_WR: assert property (s_wr |=> wr_cached ^ wr_direct)
    else $error("bad answer");
  AST_FRC: assert property (wr_req && wr_forced |=> !wr_cached)
    else $error("forced cached");
  AST_BSY: assert property (busy && wr_req |=> !wr_cached)
    else $error("cached in flush");
  AST_CMT: assert property (nvm_commit |=> !nvm_commit [*3])
    else $error("fast commit");
  AST_CMD: assert property (cmd0_rst |=> (!busy && !wr_cached)[*2])
    else $error("cache after reset");
endmodule // mwcb_checker
bind mwcb_top mwcb_checker u_chk (.*);

// File: tb/mwcb_host.sv
`timescale 1ns/10ps
module mwcb_host (
  input wire ref_clk, // Clock
  input wire rst_b, // Reset
  input wire go, // Start burst
  input wire [7:0] n_blk, // Burst length
  input wire forced, // Forced burst
  input wire wr_cached, // Cached answer
  input wire wr_direct, // Direct answer
  output reg wr_req, // Write pulse
  output reg wr_forced, // Forced flag
  output reg [7:0] n_cached, // Cached count
  output reg [7:0] n_direct // Direct count
);
  reg [7:0] left_q;
  // One block a cycle; forced flag on every block of a forced burst
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 8'h00;
      wr_req <= 1'b0;
      wr_forced <= 1'b0;
      n_cached <= 8'h00;
      n_direct <= 8'h00;
    end else begin
      left_q <= go ? n_blk : left_q - {7'h0, left_q != 8'h00};
      wr_req <= left_q != 8'h00;
      wr_forced <= forced && left_q != 8'h00;
      n_cached <= n_cached + {7'h0, wr_cached};
      n_direct <= n_direct + {7'h0, wr_direct};
    end
  end
endmodule // mwcb_host

// File: tb/mwcb_tb.sv
`timescale 1ns/10ps
`include "mwcb_regs.vh"
module mwcb_tb;
  logic ref_clk, rst_b, psel, penable, pwrite, hw_rst_pin_b, cmd0_rst;
  logic nvm_err, wr_req, wr_forced, go, forced, pready, pslverr, err;
  logic wr_cached, wr_direct, nvm_commit, busy, irq;
  logic [1:0] nvm_epoch;
  logic [1:0] ep [$];
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] n_blk, n_cached, n_direct;
  int n_errors, cmp_count;
  mwcb_top DUT (.*);
  mwcb_host host (.*);
  // Clock, commit log, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (nvm_commit === 1'b1) ep.push_back(nvm_epoch);
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  ////////////////////////////////////////
  // Compare, verdict, bus and write tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [9:0] ix,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input string nm, input logic [9:0] ix,
    input logic [31:0] e);
    apb(1'b0, ix, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic burst(input logic [7:0] n, input logic f);
    n_blk <= n;
    forced <= f;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (n + 3) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////
  // Test sequence
  initial begin
    rst_b = 1'b0;
    hw_rst_pin_b = 1'b1;
    {psel, penable, pwrite, cmd0_rst, nvm_err, go, forced} = '0;
    {paddr, pwdata, n_blk} = '0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rdc("cap", `MWCB_IX_CAP, 32'h1);
    apb(1'b1, `MWCB_IX_POL, 32'hff);
    rdc("policy", `MWCB_IX_POL, 32'h0);
    rdc("cache", `MWCB_IX_CEN, 32'h0);
    apb(1'b0, 10'h100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    burst(8'h2, 1'b0);
    chk("direct", 32'h2, {24'h0, n_direct});
    apb(1'b1, `MWCB_IX_MSK, 32'h7);
    apb(1'b1, `MWCB_IX_CEN, 32'h1);
    apb(1'b1, `MWCB_IX_FEN, 32'h1);
    ep.delete();
    burst(8'h3, 1'b0);
    apb(1'b1, `MWCB_IX_FLT, 32'h2);
    chk("fence_err", 32'h0, {31'h0, err});
    burst(8'h2, 1'b0);
    chk("cached", 32'h5, {24'h0, n_cached});
    repeat (40) @(posedge ref_clk);
    chk("commits", 32'h5, ep.size());
    chk("ep_a", {30'h0, ep[0]}, {30'h0, ep[2]});
    chk("ep_b", 32'h1, {31'h0, ep[3] !== ep[2]});
    burst(8'h8, 1'b0);
    apb(1'b1, `MWCB_IX_CEN, 32'h0);
    chk("busy", 32'h1, {31'h0, busy});
    for (int t = 0; t < 400 && busy !== 1'b0; t++) @(posedge ref_clk);
    chk("idle", 32'h0, {31'h0, busy});
    @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("status", `MWCB_IX_ST, 32'h1);
    @(posedge ref_clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    nvm_err <= 1'b1;
    @(posedge ref_clk);
    nvm_err <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc("err", `MWCB_IX_ST, 32'h2);
    apb(1'b1, `MWCB_IX_CEN, 32'h1);
    apb(1'b1, `MWCB_IX_FLT, 32'h1);
    burst(8'h1, 1'b1);
    chk("forced", 32'h3, {24'h0, n_direct});
    cmd0_rst <= 1'b1;
    @(posedge ref_clk);
    cmd0_rst <= 1'b0;
    rdc("cmd0", `MWCB_IX_CEN, 32'h0);
    apb(1'b1, `MWCB_IX_CEN, 32'h1);
    hw_rst_pin_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    hw_rst_pin_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdc("pin", `MWCB_IX_CEN, 32'h0);
    end_of_test;
  end
endmodule // mwcb_tb
